// *** logic/smr_safe_mode_request_monitor.sv ***
// Safe mode request monitor: requests and watches an actuator's safe mode.
//
// Overview of operation
// (RQ1) No acknowledge before the timeout expires gives timeout error, C003.
// (RQ2) Acknowledge dropping in the safe state gives ack-lost error, C002.
// (RQ3) Request withdrawn before the actuator acknowledged is an error.
// (RQ4) A fault reset stuck true is an error, never a valid reset.
// (RQ5) Reset already true on entering acknowledge-lost reports code C004.
// (RQ6) Reset already true on entering timeout error reports code C005.
// (RQ7) Any error state forces safe-confirmed false whatever the acknowledge.
// (RQ8) Leaving an error needs a false-to-true edge on fault reset.
// (RQ9) After error reset, operation resumes only once mode request is true.
// (RQ10) No error information comes from the actuator, only its acknowledge.
// (RQ11) Idle, the default, shows code 0000 with every flag false.
// (RQ12) Confirmed safe mode shows 8000, ready and safe-confirmed true.
// (RQ13) Enable true gives init, code 8001, error true; a fault reset edge leaves it.
// (RQ14) Operation mode shows 8002, ready true, safe-confirmed false.
// (RQ15) Enable low returns to idle from any state, above all else.
// (RQ16) Mode request false asks safe mode; acknowledge true means safe.
// (RQ17) Timeout runs from mode request falling to acknowledge rising.
// (RQ18) Diagnostic code is a 16-bit word reset to zero.
// (RQ19) One evaluation per clock; timeout is a down-counter of cycles.
// (RQ20) Previous fault reset level is kept to tell an edge from a level.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module smr_safe_mode_request_monitor (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        enable_in,
	input  wire logic        op_mode_request_in,
	input  wire logic        fault_reset_in,
	input  wire logic        safe_ack_in,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             ready_out,
	output logic             safe_confirmed_out,
	output logic             actuator_mode_request_out,
	output logic             error_out,
	output logic      [15:0] diagnostic_code
);

	logic                enable_s;
	logic                op_mode_s;
	logic                reset_s;
	logic                ack_s;
	logic                reset_prev_q;
	logic                reset_rise;
	logic [31:0]         ack_timeout_q;
	logic [31:0]         timer_q;
	logic [31:0]         timer_d;
	logic                timer_zero;
	smr_pkg::smr_state_t state_q;
	smr_pkg::smr_state_t state_d;
	logic                ready_d;
	logic                safe_d;
	logic                req_d;
	logic                error_d;
	logic [15:0]         diag_d;

	// All four levels come from outside this clock domain.
	smr_sync2 u_sync_enable (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (enable_in),
		.q     (enable_s)
	);

	smr_sync2 u_sync_op_mode (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (op_mode_request_in),
		.q     (op_mode_s)
	);

	smr_sync2 u_sync_reset (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (fault_reset_in),
		.q     (reset_s)
	);

	// The acknowledge is the only input taken from the actuator.
	smr_sync2 u_sync_ack (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (safe_ack_in),
		.q     (ack_s)
	); // RQ10

	// Previous fault reset level, so an edge is told apart from a level.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_prev_q <= smr_pkg::FLAG_RST;
		end else begin
			reset_prev_q <= reset_s; // RQ20
		end
	end

	assign reset_rise = reset_s & ~reset_prev_q; // RQ20

	// Timeout register written by software, in clock cycles.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_timeout_q <= smr_pkg::ACK_TIMEOUT_RST; // RQ17
		end else if (reg_wr && reg_addr == smr_pkg::ADDR_ACK_TIMEOUT) begin
			ack_timeout_q <= reg_wdata;
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == smr_pkg::ADDR_ACK_TIMEOUT) begin
				reg_rdata <= ack_timeout_q;
			end else if (reg_addr == smr_pkg::ADDR_STATUS) begin
				reg_rdata <= '0;
				reg_rdata[smr_pkg::STAT_DIAG_LSB +: 16] <= diagnostic_code;
				reg_rdata[smr_pkg::STAT_READY_BIT] <= ready_out;
				reg_rdata[smr_pkg::STAT_SAFE_BIT] <= safe_confirmed_out;
				reg_rdata[smr_pkg::STAT_REQ_BIT] <= actuator_mode_request_out;
				reg_rdata[smr_pkg::STAT_ERROR_BIT] <= error_out;
				reg_rdata[smr_pkg::STAT_ACK_BIT] <= ack_s;
			end else begin
				reg_rdata <= '0;
			end
		end else begin
			reg_rdata <= '0;
		end
	end

	assign timer_zero = (timer_q == '0);

	// Next state, evaluated once per clock cycle.
	always_comb begin
		state_d = state_q;
		case (state_q)
			smr_pkg::ST_IDLE: begin
				state_d = smr_pkg::ST_INIT; // RQ13
			end
			smr_pkg::ST_INIT: begin
				// A reset level held since enable is not accepted.
				if (reset_rise) begin // RQ4
					state_d = smr_pkg::ST_WAIT_CONF;
				end
			end
			smr_pkg::ST_WAIT_CONF: begin
				if (ack_s) begin
					state_d = smr_pkg::ST_SAFE;
				end else if (op_mode_s) begin
					// Safe request withdrawn before confirmation.
					state_d = reset_s ? smr_pkg::ST_RESET_ERR3
						: smr_pkg::ST_TIMEOUT; // RQ3
				end else if (timer_zero) begin
					state_d = reset_s ? smr_pkg::ST_RESET_ERR3
						: smr_pkg::ST_TIMEOUT; // RQ1
				end
			end
			smr_pkg::ST_SAFE: begin
				if (!ack_s) begin
					state_d = reset_s ? smr_pkg::ST_RESET_ERR2
						: smr_pkg::ST_ACK_LOST; // RQ2
				end else if (op_mode_s) begin
					state_d = smr_pkg::ST_WAIT_CONF_OP; // RQ16
				end
			end
			smr_pkg::ST_WAIT_CONF_OP: begin
				if (!op_mode_s) begin
					state_d = smr_pkg::ST_SAFE;
				end else if (!ack_s) begin
					state_d = smr_pkg::ST_OPMODE;
				end
			end
			smr_pkg::ST_OPMODE: begin
				if (!op_mode_s) begin
					state_d = smr_pkg::ST_WAIT_CONF; // RQ17
				end
			end
			smr_pkg::ST_WAIT_OPMODE: begin
				if (op_mode_s) begin
					state_d = smr_pkg::ST_OPMODE; // RQ9
				end
			end
			smr_pkg::ST_ACK_LOST,
			smr_pkg::ST_TIMEOUT: begin
				if (reset_rise) begin
					state_d = smr_pkg::ST_WAIT_OPMODE; // RQ8
				end
			end
			smr_pkg::ST_RESET_ERR2: begin
				// Stays until the stuck reset is released.
				if (!reset_s) begin
					state_d = smr_pkg::ST_ACK_LOST; // RQ4
				end
			end
			smr_pkg::ST_RESET_ERR3: begin
				if (!reset_s) begin
					state_d = smr_pkg::ST_TIMEOUT; // RQ4
				end
			end
			default: begin
				state_d = smr_pkg::ST_IDLE;
			end
		endcase
		if (!enable_s) begin
			state_d = smr_pkg::ST_IDLE; // RQ15
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= smr_pkg::ST_IDLE;
		end else begin
			state_q <= state_d; // RQ19
		end
	end

	// Timeout down-counter, loaded when the safe request starts.
	always_comb begin
		timer_d = timer_q;
		if (state_d == smr_pkg::ST_WAIT_CONF
		    && state_q != smr_pkg::ST_WAIT_CONF) begin
			timer_d = ack_timeout_q; // RQ17
		end else if (state_q == smr_pkg::ST_WAIT_CONF && !timer_zero) begin
			timer_d = timer_q - 32'h0000_0001; // RQ19
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_q <= smr_pkg::ACK_TIMEOUT_RST;
		end else begin
			timer_q <= timer_d;
		end
	end

	// Output decode of the next state, so every output is a flip-flop.
	always_comb begin
		ready_d = 1'b1;
		safe_d  = 1'b0;
		req_d   = 1'b0;
		error_d = 1'b0;
		diag_d  = smr_pkg::DIAG_IDLE;
		case (state_d)
			smr_pkg::ST_IDLE: begin
				ready_d = 1'b0; // RQ11
				diag_d  = smr_pkg::DIAG_IDLE;
			end
			smr_pkg::ST_INIT: begin
				error_d = 1'b1; // RQ13
				diag_d  = smr_pkg::DIAG_INIT;
			end
			smr_pkg::ST_WAIT_CONF: begin
				diag_d  = smr_pkg::DIAG_WAIT_CONF;
			end
			smr_pkg::ST_SAFE: begin
				safe_d  = 1'b1; // RQ12
				diag_d  = smr_pkg::DIAG_SAFE;
			end
			smr_pkg::ST_WAIT_CONF_OP: begin
				req_d   = 1'b1;
				diag_d  = smr_pkg::DIAG_WAIT_CONF_OP;
			end
			smr_pkg::ST_OPMODE: begin
				req_d   = 1'b1; // RQ14
				diag_d  = smr_pkg::DIAG_OPMODE;
			end
			smr_pkg::ST_WAIT_OPMODE: begin
				error_d = 1'b1;
				diag_d  = smr_pkg::DIAG_WAIT_OPMODE;
			end
			smr_pkg::ST_ACK_LOST: begin
				error_d = 1'b1; // RQ2
				diag_d  = smr_pkg::DIAG_ACK_LOST;
			end
			smr_pkg::ST_TIMEOUT: begin
				error_d = 1'b1; // RQ1
				diag_d  = smr_pkg::DIAG_TIMEOUT;
			end
			smr_pkg::ST_RESET_ERR2: begin
				error_d = 1'b1; // RQ5
				diag_d  = smr_pkg::DIAG_RESET_ERR2;
			end
			smr_pkg::ST_RESET_ERR3: begin
				error_d = 1'b1; // RQ6
				diag_d  = smr_pkg::DIAG_RESET_ERR3;
			end
			default: begin
				ready_d = 1'b0;
			end
		endcase
		// Safe confirmation is never shown together with an error.
		if (error_d) begin
			safe_d = 1'b0; // RQ7
		end
	end

	// Each output has its own register, so none of them can glitch.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_out <= smr_pkg::FLAG_RST;
		end else begin
			ready_out <= ready_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			safe_confirmed_out <= smr_pkg::FLAG_RST;
		end else begin
			safe_confirmed_out <= safe_d; // RQ7
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			actuator_mode_request_out <= smr_pkg::FLAG_RST;
		end else begin
			actuator_mode_request_out <= req_d; // RQ16
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			error_out <= smr_pkg::FLAG_RST;
		end else begin
			error_out <= error_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			diagnostic_code <= smr_pkg::DIAG_RST; // RQ18
		end else begin
			diagnostic_code <= diag_d;
		end
	end

endmodule

// *** logic/smr_sync2.sv ***
// Two flip-flop synchroniser for one level arriving from another domain.
`timescale 1ns/1ps
module smr_sync2 (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);

	logic [1:0] stage_q;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= smr_pkg::SYNC_RST;
		end else begin
			stage_q <= {stage_q[0], d};
		end
	end

	assign q = stage_q[1];

endmodule

// *** pkg/smr_pkg.sv ***
// Constants, diagnostic codes and state type of the safe mode request monitor.
package smr_pkg;

	// Register word offsets, byte addressed, one aligned 32-bit word each.
	localparam logic [7:0]  ADDR_ACK_TIMEOUT = 8'h00;
	localparam logic [7:0]  ADDR_STATUS      = 8'h04;

	// Reset value of the acknowledge timeout, in clock cycles.
	localparam logic [31:0] ACK_TIMEOUT_RST  = 32'h0000_0000;

	// Status word field positions.
	localparam int          STAT_DIAG_LSB    = 0;
	localparam int          STAT_READY_BIT   = 16;
	localparam int          STAT_SAFE_BIT    = 17;
	localparam int          STAT_REQ_BIT     = 18;
	localparam int          STAT_ERROR_BIT   = 19;
	localparam int          STAT_ACK_BIT     = 20;

	// Diagnostic codes.
	localparam logic [15:0] DIAG_IDLE        = 16'h0000;
	localparam logic [15:0] DIAG_SAFE        = 16'h8000;
	localparam logic [15:0] DIAG_INIT        = 16'h8001;
	localparam logic [15:0] DIAG_OPMODE      = 16'h8002;
	localparam logic [15:0] DIAG_WAIT_CONF   = 16'h8003;
	localparam logic [15:0] DIAG_WAIT_OPMODE = 16'h8005;
	localparam logic [15:0] DIAG_WAIT_CONF_OP = 16'h8012;
	localparam logic [15:0] DIAG_ACK_LOST    = 16'hC002;
	localparam logic [15:0] DIAG_TIMEOUT     = 16'hC003;
	localparam logic [15:0] DIAG_RESET_ERR2  = 16'hC004;
	localparam logic [15:0] DIAG_RESET_ERR3  = 16'hC005;

	// Value of the diagnostic code, the flags and the synchroniser stages after reset.
	localparam logic [15:0] DIAG_RST         = 16'h0000;
	localparam logic        FLAG_RST         = 1'b0;
	localparam logic [1:0]  SYNC_RST         = 2'h0;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_INIT,
		ST_WAIT_CONF,
		ST_SAFE,
		ST_WAIT_CONF_OP,
		ST_OPMODE,
		ST_WAIT_OPMODE,
		ST_ACK_LOST,
		ST_TIMEOUT,
		ST_RESET_ERR2,
		ST_RESET_ERR3
	} smr_state_t;

endpackage

// *** tb/smr_actuator.sv ***
// Behavioural actuator that answers safe mode requests with an acknowledge.
`timescale 1ns/1ps
module smr_actuator #(
	parameter int DELAY = 2
) (
	input  wire logic clk,
	input  wire logic mode_req,
	input  wire logic fail,
	output logic      ack
);
	logic [7:0] cnt_q = 8'h00;
	logic       ack_q = 1'b0;

	assign ack = ack_q;

	// A failed actuator never reaches safe mode, so its acknowledge stays low.
	always @(posedge clk) begin
		if (mode_req || fail) begin
			cnt_q <= 8'h00;
			ack_q <= 1'b0;
		end else if (cnt_q == 8'(DELAY)) begin
			ack_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// *** tb/smr_asserts.sv ***
// Concurrent checks on the monitor's outputs against its inputs.
`timescale 1ns/1ps
module smr_asserts (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        enable_in,
	input wire logic        op_mode_request_in,
	input wire logic        fault_reset_in,
	input wire logic        ready_out,
	input wire logic        safe_confirmed_out,
	input wire logic        actuator_mode_request_out,
	input wire logic        error_out,
	input wire logic [15:0] diagnostic_code
);
	logic [3:0] f;
	logic [15:0] c;

	assign f = {ready_out, safe_confirmed_out, actuator_mode_request_out,
		error_out};
	assign c = diagnostic_code;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	idle_flags_a: assert property (c == 16'h0000 |-> f == 4'h0)
		else $error("idle flags wrong");
	safe_flags_a: assert property (c == 16'h8000 |-> f == 4'hC)
		else $error("safe flags wrong");
	init_flags_a: assert property (c == 16'h8001 |-> f == 4'h9)
		else $error("init flags wrong");
	opmode_flags_a: assert property (c == 16'h8002 |-> f[3:2] == 2'h2)
		else $error("operation flags wrong");
	error_flags_a: assert property (
		c inside {16'hC002, 16'hC003, 16'hC004, 16'hC005} |-> f == 4'h9)
		else $error("error state flags wrong");
	error_unsafe_a: assert property (
		error_out |-> !safe_confirmed_out)
		else $error("safe confirmed during error");
	enable_idle_a: assert property (
		$fell(enable_in) |-> ##[1:4] c == 16'h0000)
		else $error("enable low did not reach idle");
	reset_edge_a: assert property (c == 16'h8005 && $past(c) != 16'h8005
		|-> $past(fault_reset_in, 2) || $past(fault_reset_in, 3)
		|| $past(fault_reset_in, 4))
		else $error("error left without a reset edge");
	resume_mode_a: assert property (c == 16'h8002 && $past(c) == 16'h8005
		|-> op_mode_request_in)
		else $error("resumed without mode request");
endmodule

bind smr_safe_mode_request_monitor smr_asserts chk_u (.clk, .rst_n, .enable_in,
	.op_mode_request_in, .fault_reset_in, .ready_out, .safe_confirmed_out,
	.actuator_mode_request_out, .error_out, .diagnostic_code);

// *** tb/smr_safe_mode_request_monitor_bench.sv ***
// Self-checking bench for the safe mode request monitor.
`timescale 1ns/1ps
module smr_safe_mode_request_monitor_bench;
	logic        clk = 1'b0, rst_n = 1'b0, enable_in = 1'b0, fail = 1'b0;
	logic        op_mode_request_in = 1'b0, fault_reset_in = 1'b0;
	logic        safe_ack_in, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic        ready_out, safe_confirmed_out, actuator_mode_request_out;
	logic        error_out;
	logic [15:0] diagnostic_code;
	int          error_cnt = 0, checks = 0, cyc = 0;

	always #12.5 clk = ~clk;

	smr_safe_mode_request_monitor dut_u (.clk, .rst_n, .enable_in,
		.op_mode_request_in, .fault_reset_in, .safe_ack_in, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ready_out,
		.safe_confirmed_out, .actuator_mode_request_out, .error_out,
		.diagnostic_code);
	smr_actuator act_u (.clk, .mode_req(actuator_mode_request_out), .fail,
		.ack(safe_ack_in));

	task automatic wrap_up();
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_out(input logic [15:0] c, input logic [3:0] f);
		logic [19:0] g;
		g = {ready_out, safe_confirmed_out, actuator_mode_request_out,
			error_out, diagnostic_code};
		checks++;
		if (g !== {f, c}) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, {f, c});
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk_word(reg_rdata, e);
	endtask

	// Pins pass two synchronisers and a state edge, and the actuator answers.
	task automatic pins(input logic e, o, r, x, input int n);
		@(posedge clk);
		enable_in <= e;
		op_mode_request_in <= o;
		fault_reset_in <= r;
		fail <= x;
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic clear_err();
		pins(1'b1, 1'b0, 1'b1, 1'b1, 4);
		pins(1'b1, 1'b1, 1'b0, 1'b1, 12);
		chk_out(16'h8002, 4'hA);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_out(16'h0000, 4'h0);
		rd(8'h00, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		wr(8'h00, 32'h0000_000A);
		rd(8'h00, 32'h0000_000A);
		wr(8'h04, 32'hFFFF_FFFF);
		pins(1'b1, 1'b0, 1'b0, 1'b0, 12);
		chk_out(16'h8001, 4'h9);
		pins(1'b1, 1'b0, 1'b1, 1'b0, 4);
		pins(1'b1, 1'b0, 1'b0, 1'b0, 12);
		chk_out(16'h8000, 4'hC);
		rd(8'h04, 32'h0013_8000);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 12);
		chk_out(16'h8002, 4'hA);
		pins(1'b1, 1'b0, 1'b0, 1'b0, 12);
		chk_out(16'h8000, 4'hC);
		pins(1'b1, 1'b0, 1'b0, 1'b1, 12);
		chk_out(16'hC002, 4'h9);
		pins(1'b1, 1'b0, 1'b1, 1'b1, 4);
		pins(1'b1, 1'b0, 1'b0, 1'b1, 12);
		chk_out(16'h8005, 4'h9);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 12);
		chk_out(16'h8002, 4'hA);
		pins(1'b1, 1'b0, 1'b1, 1'b0, 12);
		pins(1'b1, 1'b0, 1'b1, 1'b1, 12);
		chk_out(16'hC004, 4'h9);
		pins(1'b1, 1'b0, 1'b0, 1'b1, 12);
		chk_out(16'hC002, 4'h9);
		clear_err();
		wr(8'h00, 32'h0000_0003);
		pins(1'b1, 1'b0, 1'b0, 1'b1, 12);
		chk_out(16'hC003, 4'h9);
		clear_err();
		pins(1'b1, 1'b0, 1'b1, 1'b1, 12);
		chk_out(16'hC005, 4'h9);
		pins(1'b1, 1'b0, 1'b0, 1'b1, 12);
		chk_out(16'hC003, 4'h9);
		clear_err();
		wr(8'h00, 32'h0000_00C8);
		pins(1'b1, 1'b0, 1'b0, 1'b1, 8);
		chk_out(16'h8003, 4'h8);
		pins(1'b1, 1'b1, 1'b0, 1'b1, 12);
		chk_out(16'hC003, 4'h9);
		pins(1'b0, 1'b1, 1'b0, 1'b1, 12);
		chk_out(16'h0000, 4'h0);
		wrap_up();
	end
endmodule
